// ===== rtl/ais_pkg.sv
package ais_pkg;
    // Clock and filter timing.
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAMPLE_PERIOD_US = 1000;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int TICK_W = 18;
    localparam int TAU_STEP_US = 10000;
    localparam int TAU_SAMPLES = TAU_STEP_US / SAMPLE_PERIOD_US;
    localparam int FILT_Q = 16;
    localparam int ALPHA_ONE = 1 << FILT_Q;
    // Percent values are in 0.1 % steps, gains in 0.001 steps.
    localparam int PCT_FULL = 1000;
    localparam int GAIN_UNITY = 1000;
    localparam int VOLT_FS_MV = 10000;
    localparam int CUR_FS_UA = 20000;
    localparam int CUR_LO_UA = 4000;
    localparam int CUR_SPAN_UA = 16000;
    localparam int TORQUE_FS = 2000;
    localparam int OVERLOAD_FS = 1000;
    localparam int USER_FS = 32767;
    // Field widths and reset values.
    localparam int GAIN_W = 14;
    localparam int OFF_W = 11;
    localparam int TAU_W = 11;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 18;
    localparam logic [31:0] FILT_RST = 32'h0000_0000;
    // Input range codes.
    typedef enum logic [2:0] {
        RNG_DIRECT = 3'b000,
        RNG_LIVE_ZERO = 3'b001,
        RNG_DIRECT_INV = 3'b010,
        RNG_LIVE_ZERO_INV = 3'b011,
        RNG_BIPOLAR = 3'b100
    } ais_range_e;
    // Sample intake states.
    typedef enum logic {
        ST_TAKE = 1'b0,
        ST_HOLD = 1'b1
    } ais_state_e;
endpackage

// ===== rtl/ais_top.sv
`timescale 1ns/10ps
// Functional notes
// - Input chain: normalize, offset, gain, function, filter.
// - Signed per-input offset added before gain.
// - Programmable first-order filter, zero means none.
// - Decode input range codes; bipolar only third.
// - Direct ranges scale by 10 V or 20 mA.
// - Live-zero range clamps to zero..full scale.
// - Inverted ranges give 100 % minus direct.
// - Input result stays signed, negatives kept.
// - Output source chosen by code; unused gives zero.
// - Each output source divided by its scale.
// - Per-output gain multiplies normalized value.
// - Output percentage held within zero..100 %.
// - Input percentage held within -100..100 %.

// Sample buffer with registered storage and first-word-out read.
module ais_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_i, // Clock.
    input wire logic rst_n_i, // Synchronised reset, active low.
    input wire logic ce_i, // Clock enable.
    input wire logic in_valid_i, // Write request.
    output logic in_ready_o, // Space available.
    input wire logic [WIDTH-1:0] in_data_i, // Write word.
    output logic out_valid_o, // Word available.
    input wire logic out_ready_i, // Read request.
    output logic [WIDTH-1:0] out_data_o // Oldest word.
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic wr_en, rd_en;

    // Pointer bookkeeping; the extra bit tells full from empty.
    always_comb begin
        in_ready_o = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
        out_valid_o = (wr_q != rd_q);
        wr_en = in_valid_i && in_ready_o && ce_i;
        rd_en = out_ready_i && out_valid_o && ce_i;
        wr_d = wr_en ? wr_q + 1'b1 : wr_q;
        rd_d = rd_en ? rd_q + 1'b1 : rd_q;
        out_data_o = mem[rd_q[AW-1:0]];
    end

    // Pointer and storage registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[wr_q[AW-1:0]] <= in_data_i;
        end
    end
endmodule // ais_fifo

module ais_top import ais_pkg::*; #(
    parameter int SAMPLE_TICK_CYCLES = SAMPLE_CYCLES
) (
    input wire logic CLK_I, // 250 MHz clock.
    input wire logic ARST_N_I, // Asynchronous reset, active low.
    input wire logic CE_I, // Clock enable; low freezes all state except the reset synchroniser.
    input wire logic SAMPLE_VALID_I, // Converter sample offered.
    output logic SAMPLE_READY_O, // Sample buffer has space.
    input wire logic [1:0] SAMPLE_CHAN_I, // Input number 0..2.
    input wire logic signed [15:0] SAMPLE_DATA_I, // Sample in mV or uA.
    input wire logic [GAIN_W-1:0] INPUT1_GAIN_I, // Gain, 0.001 steps.
    input wire logic signed [OFF_W-1:0] INPUT1_OFFSET_I, // Offset, 0.1 %.
    input wire logic [TAU_W-1:0] INPUT1_FILTER_TAU_I, // Tau, 0.01 s.
    input wire logic [2:0] INPUT1_RANGE_SELECT_I, // Range code.
    input wire logic INPUT1_IS_CURRENT_I, // Current signal when high.
    input wire logic [GAIN_W-1:0] INPUT2_GAIN_I, // Gain, 0.001 steps.
    input wire logic signed [OFF_W-1:0] INPUT2_OFFSET_I, // Offset, 0.1 %.
    input wire logic [TAU_W-1:0] INPUT2_FILTER_TAU_I, // Tau, 0.01 s.
    input wire logic [2:0] INPUT2_RANGE_SELECT_I, // Range code.
    input wire logic INPUT2_IS_CURRENT_I, // Current signal when high.
    input wire logic [GAIN_W-1:0] INPUT3_GAIN_I, // Gain, 0.001 steps.
    input wire logic signed [OFF_W-1:0] INPUT3_OFFSET_I, // Offset, 0.1 %.
    input wire logic [TAU_W-1:0] INPUT3_FILTER_TAU_I, // Tau, 0.01 s.
    input wire logic [2:0] INPUT3_RANGE_SELECT_I, // Range code.
    input wire logic INPUT3_IS_CURRENT_I, // Current signal when high.
    output logic signed [15:0] INPUT1_VALUE_PCT_O, // Result, 0.1 %.
    output logic signed [15:0] INPUT2_VALUE_PCT_O, // Result, 0.1 %.
    output logic signed [15:0] INPUT3_VALUE_PCT_O, // Result, 0.1 %.
    input wire logic [4:0] OUTPUT1_SOURCE_SELECT_I, // Source code.
    input wire logic [GAIN_W-1:0] OUTPUT1_GAIN_I, // Gain, 0.001 steps.
    input wire logic [4:0] OUTPUT2_SOURCE_SELECT_I, // Source code.
    input wire logic [GAIN_W-1:0] OUTPUT2_GAIN_I, // Gain, 0.001 steps.
    input wire logic [15:0] MAXIMUM_SPEED_LIMIT_I, // Speed full scale.
    input wire logic [15:0] RATED_DRIVE_CURRENT_I, // Rated current.
    input wire logic [15:0] PROCESS_VARIABLE_SCALE_I, // Process scale.
    input wire logic signed [15:0] SPEED_REF_I, // Speed reference.
    input wire logic signed [15:0] SPEED_REAL_I, // Actual speed.
    input wire logic signed [15:0] OUT_CURRENT_I, // Output current.
    input wire logic signed [15:0] PROCESS_VAR_I, // Process variable.
    input wire logic signed [15:0] ACTIVE_CURRENT_I, // Active current.
    input wire logic signed [15:0] PID_SETPOINT_I, // Controller setpoint.
    input wire logic signed [15:0] MOTOR_TORQUE_I, // Torque, 0.1 %.
    input wire logic signed [15:0] PLC_VALUE_I, // Programmable value.
    input wire logic signed [15:0] MOTOR_OVERLOAD_LEVEL_I, // Overload, 0.1 %.
    input wire logic signed [15:0] USER_OUTPUT_VALUE_A_I, // User value A.
    input wire logic signed [15:0] USER_OUTPUT_VALUE_B_I, // User value B.
    input wire logic signed [15:0] USER_OUTPUT_VALUE_C_I, // User value C.
    input wire logic [7:0][15:0] APP_VALUE_I, // Application values 1..8.
    output logic [15:0] OUTPUT1_VALUE_PCT_O, // Output value, 0.1 %.
    output logic [15:0] OUTPUT2_VALUE_PCT_O // Output value, 0.1 %.
);
    logic rst_meta_q, rst_n;
    logic [TICK_W-1:0] tick_q, tick_d;
    logic tick;
    ais_state_e st_q, st_d;
    logic pop, pop_ok, fifo_valid;
    logic [FIFO_WIDTH-1:0] fifo_data;
    logic [1:0] pop_ch;
    logic signed [15:0] pop_s;
    logic signed [31:0] cond_q [3], cond_d [3], filt_q [3], filt_d [3];
    logic [GAIN_W-1:0] in_gain [3];
    logic signed [OFF_W-1:0] in_off [3];
    logic [TAU_W-1:0] in_tau [3];
    logic [2:0] in_rng [3];
    logic in_cur [3];
    logic [15:0] out_q [2], out_d [2];

    // Signed widening of an unsigned field.
    function automatic logic signed [31:0] sx(input logic [15:0] u);
        return $signed({16'h0000, u});
    endfunction

    // Clamp to a signed window.
    function automatic logic signed [31:0] clampw(input logic signed [31:0] v,
                                                  input logic signed [31:0] lo,
                                                  input logic signed [31:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Conditioned input value in 0.1 % before filtering.
    function automatic logic signed [31:0] ain_cond(input logic signed [15:0] s,
                                                    input logic [2:0] rng,
                                                    input logic cur,
                                                    input logic bip,
                                                    input logic signed [OFF_W-1:0] off,
                                                    input logic [GAIN_W-1:0] gain);
        logic signed [31:0] n;
        logic signed [31:0] v;
        n = 32'sh0;
        case (rng)
            RNG_DIRECT, RNG_DIRECT_INV: begin
                n = cur ? 32'(s) * PCT_FULL / CUR_FS_UA : 32'(s) * PCT_FULL / VOLT_FS_MV;
            end
            RNG_LIVE_ZERO, RNG_LIVE_ZERO_INV: begin
                n = clampw((32'(s) - CUR_LO_UA) * PCT_FULL / CUR_SPAN_UA, 0, PCT_FULL);
            end
            RNG_BIPOLAR: begin
                n = bip ? 32'(s) * PCT_FULL / VOLT_FS_MV : 32'sh0;
            end
            default: begin
                n = 32'sh0;
            end
        endcase
        v = (n + 32'(off)) * sx(16'(gain)) / GAIN_UNITY;
        if (rng == RNG_DIRECT_INV || rng == RNG_LIVE_ZERO_INV) begin
            v = PCT_FULL - v;
        end
        return clampw(v, -PCT_FULL, PCT_FULL);
    endfunction

    // Reset release through two flip-flops.
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // Per-input configuration gathered into arrays.
    assign in_gain = '{INPUT1_GAIN_I, INPUT2_GAIN_I, INPUT3_GAIN_I};
    assign in_off = '{INPUT1_OFFSET_I, INPUT2_OFFSET_I, INPUT3_OFFSET_I};
    assign in_tau = '{INPUT1_FILTER_TAU_I, INPUT2_FILTER_TAU_I, INPUT3_FILTER_TAU_I};
    assign in_rng = '{INPUT1_RANGE_SELECT_I, INPUT2_RANGE_SELECT_I, INPUT3_RANGE_SELECT_I};
    assign in_cur = '{INPUT1_IS_CURRENT_I, INPUT2_IS_CURRENT_I, INPUT3_IS_CURRENT_I};

    // Samples queue here while the intake takes one every other cycle.
    ais_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rst_n_i(rst_n),
        .ce_i(CE_I),
        .in_valid_i(SAMPLE_VALID_I),
        .in_ready_o(SAMPLE_READY_O),
        .in_data_i({SAMPLE_CHAN_I, SAMPLE_DATA_I}),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop_ok),
        .out_data_o(fifo_data)
    );

    // Intake alternates take and hold, so the buffer can really fill.
    always_comb begin
        pop_ok = (st_q == ST_TAKE);
        pop = pop_ok && fifo_valid && CE_I;
        pop_ch = fifo_data[FIFO_WIDTH-1 -: 2];
        pop_s = $signed(fifo_data[15:0]);
        st_d = st_q;
        case (st_q)
            ST_TAKE: begin
                if (fifo_valid) begin
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                st_d = ST_TAKE;
            end
            default: begin
                st_d = ST_TAKE;
            end
        endcase
        tick = (tick_q == TICK_W'(SAMPLE_TICK_CYCLES - 1));
        tick_d = tick ? '0 : tick_q + 1'b1;
    end

    // Conditioning of each fresh sample and the fixed-rate smoother.
    always_comb begin
        logic signed [31:0] diff;
        logic signed [31:0] alpha;
        logic signed [47:0] prod;
        diff = 32'sh0;
        alpha = 32'sh0;
        prod = 48'sh0;
        for (int i = 0; i < 3; i++) begin
            cond_d[i] = cond_q[i];
            if (pop && pop_ch == 2'(i)) begin
                cond_d[i] = ain_cond(pop_s, in_rng[i], in_cur[i], i == 2,
                                     in_off[i], in_gain[i]);
            end
            filt_d[i] = filt_q[i];
            if (tick) begin
                alpha = ALPHA_ONE / (sx(16'(in_tau[i])) * TAU_SAMPLES + 1);
                diff = (cond_q[i] <<< FILT_Q) - filt_q[i];
                prod = 48'(diff) * 48'(alpha);
                filt_d[i] = filt_q[i] + 32'(prod >>> FILT_Q);
            end
        end
    end

    // Output source selection, scaling, gain and limiting.
    always_comb begin
        logic [4:0] code;
        logic signed [31:0] val;
        logic signed [31:0] scl;
        logic signed [31:0] v;
        code = 5'h00;
        val = 32'sh0;
        scl = 32'sh0;
        v = 32'sh0;
        for (int k = 0; k < 2; k++) begin
            code = (k == 0) ? OUTPUT1_SOURCE_SELECT_I : OUTPUT2_SOURCE_SELECT_I;
            val = 32'sh0;
            scl = 32'sh0;
            case (code)
                5'h00: begin val = 32'(SPEED_REF_I); scl = sx(MAXIMUM_SPEED_LIMIT_I); end
                5'h02: begin val = 32'(SPEED_REAL_I); scl = sx(MAXIMUM_SPEED_LIMIT_I); end
                5'h05: begin val = 32'(OUT_CURRENT_I); scl = 2 * sx(RATED_DRIVE_CURRENT_I); end
                5'h06: begin val = 32'(PROCESS_VAR_I); scl = sx(PROCESS_VARIABLE_SCALE_I); end
                5'h07: begin val = 32'(ACTIVE_CURRENT_I); scl = 2 * sx(RATED_DRIVE_CURRENT_I); end
                5'h09: begin val = 32'(PID_SETPOINT_I); scl = sx(PROCESS_VARIABLE_SCALE_I); end
                5'h0B: begin val = 32'(MOTOR_TORQUE_I); scl = TORQUE_FS; end
                5'h0C: begin val = 32'(PLC_VALUE_I); scl = USER_FS; end
                5'h10: begin val = 32'(MOTOR_OVERLOAD_LEVEL_I); scl = OVERLOAD_FS; end
                5'h12: begin val = 32'(USER_OUTPUT_VALUE_A_I); scl = USER_FS; end
                5'h13: begin val = 32'(USER_OUTPUT_VALUE_B_I); scl = USER_FS; end
                5'h14: begin val = 32'(USER_OUTPUT_VALUE_C_I); scl = USER_FS; end
                5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C: begin
                    val = 32'($signed(APP_VALUE_I[code - 5'h15]));
                    scl = USER_FS;
                end
                default: begin val = 32'sh0; scl = 32'sh0; end
            endcase
            v = val * sx(16'((k == 0) ? OUTPUT1_GAIN_I : OUTPUT2_GAIN_I));
            v = (scl > 0) ? v / scl : 32'sh0;
            out_d[k] = 16'(clampw(v, 0, PCT_FULL));
        end
    end

    // State registers, frozen while the clock enable is low.
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_TAKE;
            tick_q <= '0;
            cond_q <= '{default: FILT_RST};
            filt_q <= '{default: FILT_RST};
            out_q <= '{default: 16'h0000};
        end else if (CE_I) begin
            st_q <= st_d;
            tick_q <= tick_d;
            cond_q <= cond_d;
            filt_q <= filt_d;
            out_q <= out_d;
        end
    end

    assign INPUT1_VALUE_PCT_O = 16'(filt_q[0] >>> FILT_Q);
    assign INPUT2_VALUE_PCT_O = 16'(filt_q[1] >>> FILT_Q);
    assign INPUT3_VALUE_PCT_O = 16'(filt_q[2] >>> FILT_Q);
    assign OUTPUT1_VALUE_PCT_O = out_q[0];
    assign OUTPUT2_VALUE_PCT_O = out_q[1];

    // Checks on the conditioning path and the output scaling.
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    sequence take_ch0_s;
        pop && pop_ch == 2'd0 && INPUT1_GAIN_I == 14'h3E8 && INPUT1_OFFSET_I == 11'sh0;
    endsequence
    sequence take_ch2_s;
        pop && pop_ch == 2'd2 && INPUT3_GAIN_I == 14'h3E8 && INPUT3_OFFSET_I == 11'sh0;
    endsequence

    direct_volt_a: assert property (take_ch0_s ##0 (INPUT1_RANGE_SELECT_I == 3'h0
        && !INPUT1_IS_CURRENT_I && pop_s == 16'sh1388) |=> cond_q[0] == 32'sh1F4)
        else $error("direct voltage scaling wrong");
    live_zero_a: assert property (take_ch0_s ##0 (INPUT1_RANGE_SELECT_I == 3'h1
        && pop_s < 16'sh0FA0) |=> cond_q[0] == 32'sh0)
        else $error("live zero not clamped");
    invert_rng_a: assert property (take_ch0_s ##0 (INPUT1_RANGE_SELECT_I == 3'h2
        && !INPUT1_IS_CURRENT_I && pop_s == 16'sh07D0) |=> cond_q[0] == 32'sh320)
        else $error("inverted range wrong");
    bipolar_neg_a: assert property (take_ch2_s ##0 (INPUT3_RANGE_SELECT_I == 3'h4
        && pop_s == -16'sh1388) |=> cond_q[2] == -32'sh1F4)
        else $error("bipolar sign lost");
    chain_order_a: assert property (pop && pop_ch == 2'd0 && INPUT1_RANGE_SELECT_I == 3'h0
        && !INPUT1_IS_CURRENT_I && pop_s == 16'sh09C4 && INPUT1_OFFSET_I == 11'sh064
        && INPUT1_GAIN_I == 14'h7D0 |=> cond_q[0] == 32'sh2BC)
        else $error("offset and gain order wrong");
    in_bound_a: assert property ($signed(INPUT1_VALUE_PCT_O) <= 16'sh03E8
        && $signed(INPUT1_VALUE_PCT_O) >= -16'sh03E8)
        else $error("input result out of range");
    no_filter_a: assert property (tick && CE_I && INPUT1_FILTER_TAU_I == 11'h0
        |=> filt_q[0] == ($past(cond_q[0]) <<< FILT_Q))
        else $error("zero time constant not direct");
    tick_hold_a: assert property (!tick || !CE_I |=> filt_q[2] == $past(filt_q[2]))
        else $error("filter moved between ticks");
    out_bound_a: assert property (OUTPUT2_VALUE_PCT_O <= 16'h03E8)
        else $error("output above full scale");
    unused_code_a: assert property (CE_I && OUTPUT1_SOURCE_SELECT_I == 5'h01
        |=> OUTPUT1_VALUE_PCT_O == 16'h0000)
        else $error("unused source not zero");
    torque_scale_a: assert property (CE_I && OUTPUT1_SOURCE_SELECT_I == 5'h0B
        && MOTOR_TORQUE_I == 16'sh03E8 && OUTPUT1_GAIN_I == 14'h3E8
        |=> OUTPUT1_VALUE_PCT_O == 16'h01F4)
        else $error("torque scale wrong");
    out_gain_a: assert property (CE_I && OUTPUT2_SOURCE_SELECT_I == 5'h10
        && MOTOR_OVERLOAD_LEVEL_I == 16'sh00C8 && OUTPUT2_GAIN_I == 14'h0BB8
        |=> OUTPUT2_VALUE_PCT_O == 16'h0258)
        else $error("output gain wrong");
endmodule // ais_top

// ===== sim/ais_adc_model.sv
`timescale 1ns/10ps
// Converter front end: offers one sample at a time and holds it until the block takes it.
module ais_adc_model (
    input wire logic clk_i, // Clock.
    input wire logic ready_i, // Block can take a sample.
    output logic valid_o, // Sample offered.
    output logic [1:0] chan_o, // Input number.
    output logic signed [15:0] data_o // Sample in mV or uA.
);
    // Idle bus at time zero.
    initial begin
        valid_o = 1'b0;
        chan_o = 2'h0;
        data_o = 16'h0000;
    end
    // Offer a word, hold it until taken, then idle gap cycles with a scrambled bus.
    task automatic send(input logic [1:0] c, input logic signed [15:0] d, input int gap);
        @(negedge clk_i);
        valid_o = 1'b1;
        chan_o = c;
        data_o = d;
        while (ready_i !== 1'b1) begin
            @(negedge clk_i);
        end
        @(posedge clk_i);
        repeat (gap) begin
            @(negedge clk_i);
            valid_o = 1'b0;
            chan_o = ~c;
            data_o = ~d;
        end
    endtask
endmodule // ais_adc_model

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top import ais_pkg::*; ();
    logic CLK_I = 1'b0;
    logic ARST_N_I = 1'b0;
    logic CE_I = 1'b1;
    logic SAMPLE_VALID_I, SAMPLE_READY_O;
    logic [1:0] SAMPLE_CHAN_I;
    logic signed [15:0] SAMPLE_DATA_I;
    logic [GAIN_W-1:0] ig [3];
    logic signed [OFF_W-1:0] io [3];
    logic [TAU_W-1:0] it [3];
    logic [2:0] ir [3];
    logic ic [3];
    logic [GAIN_W-1:0] OUTPUT1_GAIN_I = 14'h03E8, OUTPUT2_GAIN_I = 14'h09C4;
    logic [4:0] OUTPUT1_SOURCE_SELECT_I = 5'h00, OUTPUT2_SOURCE_SELECT_I = 5'h00;
    logic [15:0] MAXIMUM_SPEED_LIMIT_I = 16'h03E8, RATED_DRIVE_CURRENT_I = 16'h01F4;
    logic [15:0] PROCESS_VARIABLE_SCALE_I = 16'h03E8;
    logic signed [15:0] SPEED_REF_I = 16'h0064, SPEED_REAL_I = 16'h00C8, OUT_CURRENT_I = 16'h012C;
    logic signed [15:0] PROCESS_VAR_I = 16'h0190, ACTIVE_CURRENT_I = 16'hFE0C;
    logic signed [15:0] PID_SETPOINT_I = 16'h0258, MOTOR_TORQUE_I = 16'h03E8;
    logic signed [15:0] PLC_VALUE_I = 16'h4000, MOTOR_OVERLOAD_LEVEL_I = 16'h0320;
    logic signed [15:0] USER_OUTPUT_VALUE_A_I = 16'h0CCD, USER_OUTPUT_VALUE_B_I = 16'h199A;
    logic signed [15:0] USER_OUTPUT_VALUE_C_I = 16'h2667;
    logic [7:0][15:0] APP_VALUE_I;
    logic signed [15:0] INPUT1_VALUE_PCT_O, INPUT2_VALUE_PCT_O, INPUT3_VALUE_PCT_O;
    logic [15:0] OUTPUT1_VALUE_PCT_O, OUTPUT2_VALUE_PCT_O;
    int fails = 0;
    int check_count = 0;
    int refused = 0;

    // Clock of 4 ns period.
    always #2 CLK_I = ~CLK_I;

    // Count cycles in which the full buffer turned away an offered word, sampled after edges settle.
    always @(posedge CLK_I) begin
        #1;
        if (SAMPLE_VALID_I === 1'b1 && SAMPLE_READY_O === 1'b0) refused++;
    end

    ais_adc_model i_ais_adc_model (.clk_i(CLK_I), .ready_i(SAMPLE_READY_O),
        .valid_o(SAMPLE_VALID_I), .chan_o(SAMPLE_CHAN_I), .data_o(SAMPLE_DATA_I));

    ais_top #(.SAMPLE_TICK_CYCLES(8)) i_ais_top (
        .INPUT1_GAIN_I(ig[0]), .INPUT2_GAIN_I(ig[1]), .INPUT3_GAIN_I(ig[2]),
        .INPUT1_OFFSET_I(io[0]), .INPUT2_OFFSET_I(io[1]), .INPUT3_OFFSET_I(io[2]),
        .INPUT1_FILTER_TAU_I(it[0]), .INPUT2_FILTER_TAU_I(it[1]), .INPUT3_FILTER_TAU_I(it[2]),
        .INPUT1_RANGE_SELECT_I(ir[0]), .INPUT2_RANGE_SELECT_I(ir[1]),
        .INPUT3_RANGE_SELECT_I(ir[2]), .INPUT1_IS_CURRENT_I(ic[0]),
        .INPUT2_IS_CURRENT_I(ic[1]), .INPUT3_IS_CURRENT_I(ic[2]), .*);

    // Compare one value and count it.
    task automatic check(input string nm, input logic signed [31:0] got,
                         input logic signed [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Result of one input channel.
    function automatic logic signed [15:0] pct(input int ch);
        return (ch == 0) ? INPUT1_VALUE_PCT_O : (ch == 1) ? INPUT2_VALUE_PCT_O : INPUT3_VALUE_PCT_O;
    endfunction

    // Expected output percentage for a source code and gain.
    function automatic int out_exp(input int c, input int g);
        int v, s, r;
        v = 0;
        s = 0;
        case (c)
            0: begin v = SPEED_REF_I; s = MAXIMUM_SPEED_LIMIT_I; end
            2: begin v = SPEED_REAL_I; s = MAXIMUM_SPEED_LIMIT_I; end
            5: begin v = OUT_CURRENT_I; s = 2 * RATED_DRIVE_CURRENT_I; end
            6: begin v = PROCESS_VAR_I; s = PROCESS_VARIABLE_SCALE_I; end
            7: begin v = ACTIVE_CURRENT_I; s = 2 * RATED_DRIVE_CURRENT_I; end
            9: begin v = PID_SETPOINT_I; s = PROCESS_VARIABLE_SCALE_I; end
            11: begin v = MOTOR_TORQUE_I; s = 2000; end
            12: begin v = PLC_VALUE_I; s = 32767; end
            16: begin v = MOTOR_OVERLOAD_LEVEL_I; s = 1000; end
            18: begin v = USER_OUTPUT_VALUE_A_I; s = 32767; end
            19: begin v = USER_OUTPUT_VALUE_B_I; s = 32767; end
            20: begin v = USER_OUTPUT_VALUE_C_I; s = 32767; end
            default: if (c >= 21 && c <= 28) begin
                v = $signed(APP_VALUE_I[c-21]);
                s = 32767;
            end
        endcase
        r = (s <= 0) ? 0 : v * g / s;
        return (r < 0) ? 0 : (r > 1000) ? 1000 : r;
    endfunction

    // Hold reset 12 cycles, check the idle state, release.
    task automatic do_reset();
        @(negedge CLK_I);
        ARST_N_I = 1'b0;
        repeat (12) @(negedge CLK_I);
        check("ready in reset", SAMPLE_READY_O, 1);
        check("input1 in reset", INPUT1_VALUE_PCT_O, 0);
        check("output1 in reset", OUTPUT1_VALUE_PCT_O, 0);
        ARST_N_I = 1'b1;
        repeat (4) @(negedge CLK_I);
    endtask

    // Configure one input with no filtering, send one sample, check the result.
    task automatic in_case(input int ch, input logic [2:0] r, input logic cur, input int g,
                           input int off, input int smp, input int exp);
        @(negedge CLK_I);
        ir[ch] = r;
        ic[ch] = cur;
        ig[ch] = GAIN_W'(g);
        io[ch] = OFF_W'(off);
        it[ch] = '0;
        i_ais_adc_model.send(2'(ch), 16'(smp), 1);
        repeat (30) @(negedge CLK_I);
        check("input value", pct(ch), exp);
    endtask

    // Every range code, offsets, clamps and gain limits.
    task automatic t_ranges();
        in_case(0, RNG_DIRECT, 0, 1000, 0, 5000, 500);
        in_case(1, RNG_DIRECT, 1, 1000, 0, 10000, 500);
        in_case(0, RNG_DIRECT, 0, 1000, -700, 5000, -200);
        in_case(1, RNG_LIVE_ZERO, 1, 1000, -800, 12000, -300);
        in_case(0, RNG_LIVE_ZERO, 1, 1000, 0, 2000, 0);
        in_case(0, RNG_LIVE_ZERO, 1, 1000, 0, 25000, 1000);
        in_case(1, RNG_DIRECT_INV, 0, 1000, 0, 2500, 750);
        in_case(1, RNG_DIRECT_INV, 0, 1000, 100, 2000, 700);
        in_case(0, RNG_DIRECT_INV, 0, 1000, 0, 2000, 800);
        in_case(0, RNG_DIRECT, 0, 2000, 100, 2500, 700);
        in_case(2, RNG_LIVE_ZERO_INV, 1, 1000, 0, 8000, 750);
        in_case(2, RNG_BIPOLAR, 0, 1000, 0, -5000, -500);
        in_case(0, RNG_BIPOLAR, 0, 1000, 0, 5000, 0);
        in_case(2, RNG_DIRECT, 0, 2000, 0, 8000, 1000);
        in_case(2, RNG_DIRECT, 0, 2500, 0, 2000, 500);
        in_case(2, RNG_DIRECT, 0, 0, 0, 5000, 0);
    endtask

    // A step with a short time constant moves part way, then tau zero jumps to target.
    task automatic t_filter();
        in_case(0, RNG_DIRECT, 0, 1000, 0, 0, 0);
        it[0] = 11'h001;
        i_ais_adc_model.send(2'h0, 16'sh1388, 1);
        repeat (30) @(negedge CLK_I);
        check("filter partway", (INPUT1_VALUE_PCT_O > 0) && (INPUT1_VALUE_PCT_O < 500), 1);
        it[0] = 11'h000;
        repeat (20) @(negedge CLK_I);
        check("filter bypass", INPUT1_VALUE_PCT_O, 500);
    endtask

    // Fill the buffer with discarded words until it refuses, then let it drain.
    task automatic t_fifo();
        refused = 0;
        for (int k = 0; k < 40; k++) i_ais_adc_model.send(2'h3, 16'(k), (k == 39) ? 1 : 0);
        check("refusals seen", refused > 0, 1);
        repeat (60) @(negedge CLK_I);
        check("ready after drain", SAMPLE_READY_O, 1);
        check("discarded channel", INPUT1_VALUE_PCT_O, 500);
    endtask

    // Every source code on both outputs, second one with gain 2.5.
    task automatic t_outputs();
        for (int c = 0; c < 32; c++) begin
            @(negedge CLK_I);
            OUTPUT1_SOURCE_SELECT_I = 5'(c);
            OUTPUT2_SOURCE_SELECT_I = 5'(c);
            repeat (2) @(negedge CLK_I);
            check("output1 value", OUTPUT1_VALUE_PCT_O, out_exp(c, 1000));
            check("output2 value", OUTPUT2_VALUE_PCT_O, out_exp(c, 2500));
        end
    endtask

    // Clock enable low freezes the output; the new gain lands once it runs again.
    task automatic t_freeze();
        @(negedge CLK_I);
        MOTOR_OVERLOAD_LEVEL_I = 16'sh00C8;
        OUTPUT1_SOURCE_SELECT_I = 5'h10;
        OUTPUT2_SOURCE_SELECT_I = 5'h10;
        OUTPUT2_GAIN_I = 14'h0BB8;
        repeat (2) @(negedge CLK_I);
        check("output2 gain", OUTPUT2_VALUE_PCT_O, 600);
        CE_I = 1'b0;
        OUTPUT1_GAIN_I = 14'h270F;
        repeat (3) @(negedge CLK_I);
        check("frozen output", OUTPUT1_VALUE_PCT_O, 200);
        CE_I = 1'b1;
        repeat (2) @(negedge CLK_I);
        check("gain clamped", OUTPUT1_VALUE_PCT_O, 1000);
    endtask

    // Main sequence.
    initial begin
        for (int k = 0; k < 3; k++) begin
            ig[k] = 14'h03E8;
            io[k] = '0;
            it[k] = '0;
            ir[k] = 3'h0;
            ic[k] = 1'b0;
        end
        for (int k = 0; k < 8; k++) APP_VALUE_I[k] = 16'(3277 * (k + 1));
        do_reset();
        t_ranges();
        t_filter();
        t_fifo();
        t_outputs();
        t_freeze();
        do_reset();
        results();
    end

    // Watchdog well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge CLK_I);
        fails++;
        $display("BAD watchdog expected finish seen timeout");
        results();
    end
endmodule // tb_top
